//--- src/pslpc_top.sv
// Strap latch and pin control with AHB-Lite register access.
// Assumes a single AHB-Lite master; hready equals our hreadyout.
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module pslpc_top import pslpc_pkg::*; #(
	parameter int N_IO = 8
) (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            hsel,
	input  wire logic [7:0]      haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic [31:0]          hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	input  wire logic            strap_addr_bit0,
	input  wire logic            strap_addr_bit1,
	input  wire logic            strap_addr_bit2,
	input  wire logic            strap_addr_bit3,
	input  wire logic            strap_addr_bit4,
	input  wire logic            output_float_ctl,
	input  wire logic            test_select,
	input  wire logic [N_IO-1:0] core_out,
	input  wire logic [N_IO-1:0] core_oe,
	output logic [N_IO-1:0]      pin_out,
	output logic [N_IO-1:0]      pin_oe,
	input  wire logic            mgmt_valid,
	input  wire logic [4:0]      mgmt_addr,
	output logic                 mgmt_accept,
	output logic                 isolated,
	output logic                 test_mode,
	output logic                 strap_ready
);
	logic [4:0]  addr_q;
	logic        done_q;
	logic [31:0] ctrl_q;
	logic [31:0] hrdata_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;

	pslpc_strap_capture #(
		.SETTLE(PSLPC_SETTLE_CYC)
	) u_cap (
		.hclk    (hclk),
		.hresetn (hresetn),
		.strap_in({strap_addr_bit0, strap_addr_bit1, strap_addr_bit2,
			strap_addr_bit3, strap_addr_bit4}),
		.addr_q  (addr_q),
		.done_q  (done_q)
	);

	// Captured vector is bit0 at msb so the register shows bit0 at 8, bit4 at 4.
	wire [4:0] addr_num = {addr_q[0], addr_q[1], addr_q[2], addr_q[3], addr_q[4]};
	wire       ctrl_iso = ctrl_q[PSLPC_ISO_BIT];

	// (RULE2) Zero address isolates
	assign isolated = !done_q || (addr_num == PSLPC_ISO_ADDR) || ctrl_iso;

	// (RULE6) Test mode select
	assign test_mode = test_select;
	assign strap_ready = done_q;

	// (RULE3) Float all outputs
	assign pin_out = output_float_ctl ? '0 : core_out;
	assign pin_oe  = output_float_ctl ? '0 : core_oe;

	// (RULE7) Address match gate
	wire addr_match = done_q && !isolated && (mgmt_addr == addr_num);
	assign mgmt_accept = mgmt_valid && addr_match;

	wire       take    = hsel && hready && htrans[1];
	wire       rd_take = take && !hwrite;
	wire [7:0] a_word  = {haddr[7:2], 2'b00};

	// Places a one-bit flag at its field position in a register word.
	function automatic logic [31:0] pslpc_bit(input logic v, input int pos);
		pslpc_bit = 32'(v) << pos;
	endfunction

	wire [31:0] strap_word = (32'(addr_q) << PSLPC_ADDR_LSB) | pslpc_bit(ctrl_iso, PSLPC_ISO_BIT);
	wire [31:0] stat_word  = pslpc_bit(output_float_ctl, PSLPC_OFLOAT_BIT)
		| pslpc_bit(test_select, PSLPC_TEST_BIT) | pslpc_bit(isolated, PSLPC_ISOST_BIT);
	wire [31:0] mgmt_word  = pslpc_bit(addr_match, PSLPC_MATCH_BIT);
	wire [31:0] rd_word    = (a_word == PSLPC_OFS_STRAP)  ? strap_word :
				 (a_word == PSLPC_OFS_CTRL)   ? ctrl_q :
				 (a_word == PSLPC_OFS_STATUS) ? stat_word :
				 (a_word == PSLPC_OFS_MGMT)   ? mgmt_word : 32'h0000_0000;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	// (RULE4) Reset initializes all
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
		end else begin
			wr_pend_q <= take && hwrite;
			wr_addr_q <= a_word;
			if (rd_take) begin
				hrdata_q <= rd_word;
			end
		end
	end

	// Only the isolate bit of the control word is writable.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= PSLPC_CTRL_RST;
		end else if (wr_pend_q && (wr_addr_q == PSLPC_OFS_CTRL)) begin
			ctrl_q <= hwdata & (32'h0000_0001 << PSLPC_ISO_BIT);
		end
	end

	// (RULE2) Zero address isolates
	a_iso_zero: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE2)
		(done_q && addr_num == PSLPC_ISO_ADDR) |-> isolated && !mgmt_accept)
		else $error("zero address not isolated");

	// (RULE2) Isolated until latched
	a_iso_unlatched: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE2)
		!done_q |-> isolated)
		else $error("not isolated before straps latched");

	// (RULE2) Control bit isolates
	a_iso_ctrl: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE2)
		ctrl_iso |-> isolated)
		else $error("isolate control bit ignored");

	// (RULE2) No stray isolation
	a_iso_cause: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE2)
		isolated |-> (!done_q || addr_num == PSLPC_ISO_ADDR || ctrl_iso))
		else $error("isolated without a cause");

	// (RULE3) Enables drop floating
	a_float_pins: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE3)
		output_float_ctl |-> (pin_oe == '0))
		else $error("output enabled while floating");

	// (RULE3) Data drops floating
	a_float_low: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE3)
		output_float_ctl |-> (pin_out == '0))
		else $error("output data driven while floating");

	// (RULE3) Pins follow core
	a_pins_follow: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE3)
		!output_float_ctl |-> (pin_out == core_out) && (pin_oe == core_oe))
		else $error("pins not following core drive");

	// (RULE7) Only matching address
	a_mgmt_match: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE7)
		mgmt_accept |-> (mgmt_addr == addr_num) && done_q)
		else $error("management answered wrong address");

	// (RULE7) Matching address answered
	a_mgmt_accept: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE7)
		(mgmt_valid && done_q && !isolated && mgmt_addr == addr_num) |-> mgmt_accept)
		else $error("matching management request refused");

	// (RULE7) Silent while isolated
	a_mgmt_iso: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE7)
		isolated |-> !mgmt_accept)
		else $error("management answered while isolated");

	// (RULE6) Test mode select
	a_test_follow: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE6)
		test_mode == test_select)
		else $error("test mode not following select");

	// (RULE4) Nothing latched early
	a_reset_release: assert property (@(posedge hclk) // (RULE4)
		$rose(hresetn) |-> !done_q ##1 !done_q)
		else $error("straps latched too early");

	// (RULE4) State cleared in reset
	a_reset_outputs: assert property (@(posedge hclk) // (RULE4)
		!hresetn |=> (hrdata == '0) && !strap_ready && isolated && !mgmt_accept)
		else $error("state not cleared by reset");

	// (RULE4) Bus always answers okay
	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE4)
		hreadyout && !hresp)
		else $error("bus response not okay");

	// (RULE1) Strap word readback
	a_strap_read: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE1)
		(rd_take && a_word == PSLPC_OFS_STRAP) |=> hrdata[8:4] == addr_q)
		else $error("strap register mismatch");

	// (RULE1) Ready stays up
	a_ready_hold: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE1)
		strap_ready |=> strap_ready)
		else $error("strap ready dropped");

	// (RULE2) Isolate bit written
	a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE2)
		(wr_pend_q && wr_addr_q == PSLPC_OFS_CTRL) |=>
		ctrl_q[PSLPC_ISO_BIT] == $past(hwdata[PSLPC_ISO_BIT]))
		else $error("isolate control write lost");

	// (RULE2) Control holds otherwise
	a_ctrl_hold: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE2)
		!(wr_pend_q && wr_addr_q == PSLPC_OFS_CTRL) |=> $stable(ctrl_q))
		else $error("control word changed without write");

	// (RULE3) Status word readback
	a_stat_read: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE3)
		(rd_take && a_word == PSLPC_OFS_STATUS) |=> (hrdata[2] == $past(isolated))
		&& (hrdata[1] == $past(test_select)) && (hrdata[0] == $past(output_float_ctl)))
		else $error("status register mismatch");

	// (RULE7) Match flag readback
	a_mgmt_read: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE7)
		(rd_take && a_word == PSLPC_OFS_MGMT) |=> hrdata[0] == $past(addr_match))
		else $error("match register mismatch");

	// (RULE1) Unmapped reads zero
	a_unmapped: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE1)
		(rd_take && a_word != PSLPC_OFS_STRAP && a_word != PSLPC_OFS_CTRL
		&& a_word != PSLPC_OFS_STATUS && a_word != PSLPC_OFS_MGMT) |=> hrdata == '0)
		else $error("unmapped read not zero");
endmodule

//--- src/pslpc_pkg.sv
// Constants for the strap latch and pin control block.
// Assumes one 125 MHz clock and an AHB-Lite register port.
// Operation
// (RULE1) Latch five strap address bits at reset
// (RULE2) Zero address forces isolated condition
// (RULE3) Float control tristates outputs, bidirs input
// (RULE4) Logic held initialized while reset low
// (RULE5) Reset source holds reset 30 ms; the board model holds it for HOLD = 8 hclk cycles
// (RULE6) Test select one enables test mode
// (RULE7) Answer only matching management address
package pslpc_pkg;
	localparam logic [7:0]  PSLPC_OFS_STRAP  = 8'h44;
	localparam logic [7:0]  PSLPC_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  PSLPC_OFS_STATUS = 8'h04;
	localparam logic [7:0]  PSLPC_OFS_MGMT   = 8'h08;
	localparam int          PSLPC_ADDR_LSB   = 4;
	localparam int          PSLPC_ISO_BIT    = 10;
	localparam int          PSLPC_OFLOAT_BIT = 0;
	localparam int          PSLPC_TEST_BIT   = 1;
	localparam int          PSLPC_ISOST_BIT  = 2;
	localparam int          PSLPC_MATCH_BIT  = 0;
	localparam logic [4:0]  PSLPC_ISO_ADDR   = 5'h00;
	localparam logic [31:0] PSLPC_CTRL_RST   = 32'h0000_0000;
	localparam int          PSLPC_RESET_MS   = 30;
	localparam int          PSLPC_CLK_MHZ    = 125;
	localparam int          PSLPC_SETTLE_CYC = 3;
	localparam longint      PSLPC_RESET_CYC  = longint'(PSLPC_RESET_MS) * 1000 * PSLPC_CLK_MHZ;
	typedef enum logic [1:0] {PSLPC_ST_RESET, PSLPC_ST_SETTLE, PSLPC_ST_RUN} pslpc_state_t;
endpackage

//--- src/pslpc_strap_capture.sv
// Strap sampler: takes the address straps once after reset release.
// Assumes strap pins are steady levels synchronous to hclk.
`timescale 1ns/1ps
module pslpc_strap_capture import pslpc_pkg::*; #(
	parameter int SETTLE = PSLPC_SETTLE_CYC
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [4:0] strap_in,
	output logic [4:0]      addr_q,
	output logic            done_q
);
	pslpc_state_t state_q;
	logic [3:0]   cnt_q;
	wire          settle_end = (cnt_q == 4'(SETTLE - 1));

	// (RULE1) Sample after release
	// Straps are caught a few cycles after release, never under the async reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= PSLPC_ST_RESET;
			cnt_q   <= 4'h0;
			addr_q  <= 5'h00;
			done_q  <= 1'b0;
		end else begin
			case (state_q)
				PSLPC_ST_RESET: begin
					state_q <= PSLPC_ST_SETTLE;
				end
				PSLPC_ST_SETTLE: begin
					cnt_q <= cnt_q + 4'h1;
					if (settle_end) begin
						addr_q  <= strap_in;
						done_q  <= 1'b1;
						state_q <= PSLPC_ST_RUN;
					end
				end
				PSLPC_ST_RUN: begin
					state_q <= PSLPC_ST_RUN;
				end
				default: begin
					state_q <= PSLPC_ST_RESET;
				end
			endcase
		end
	end

	// (RULE1) Latched value holds
	a_addr_stable: assert property (@(posedge hclk) disable iff (!hresetn) // (RULE1)
		$past(done_q) |-> $stable(addr_q))
		else $error("strap address changed after latch");
endmodule

//--- verification/pslpc_board.sv
// Board model: strap levels and the system reset source.
// Assumes reset requests from the bench arrive just after hclk edges.
`timescale 1ns/1ps
module pslpc_board #(
	parameter int HOLD = 8
) (
	input  wire logic       hclk,
	input  wire logic       rst_req,
	input  wire logic [4:0] strap_val,
	output logic            hresetn,
	output logic [4:0]      straps
);
	int cnt = HOLD;
	always @(posedge hclk) cnt <= rst_req ? HOLD : (cnt > 0 ? cnt - 1 : 0);
	// Hold is shortened from the board's 30 ms to keep runs brief
	assign hresetn = (cnt == 0);
	assign straps  = strap_val;
endmodule

//--- verification/tb_top.sv
// Testbench: strap latch, isolation, pin float, test mode, management match.
// Assumes hreadyout loops back as hready and one word per transfer.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
	$display("[ERR] %0t %h %h", $time, a, e); end end
module tb_top;
	import pslpc_pkg::*;
	logic        hclk = 0, rst_req = 0, hsel = 0, hwrite = 0, mgmt_valid = 0;
	logic        output_float_ctl = 0, test_select = 0;
	logic [7:0]  haddr = 8'h00, core_out = 8'hA5, core_oe = 8'h3C, pin_out, pin_oe;
	logic [1:0]  htrans = 2'h0;
	logic [4:0]  strap_val = 5'h0B, mgmt_addr = 5'h00, straps;
	logic [31:0] hwdata = 32'h0, hrdata, r, e;
	logic        hresetn, hready, hresp, mgmt_accept, isolated, test_mode, strap_ready;
	int          n_errors = 0, n_compared = 0;
	pslpc_board pslpc_board_inst (.hclk, .rst_req, .strap_val, .hresetn, .straps);
	pslpc_top pslpc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
		.strap_addr_bit0(straps[0]), .strap_addr_bit1(straps[1]),
		.strap_addr_bit2(straps[2]), .strap_addr_bit3(straps[3]),
		.strap_addr_bit4(straps[4]), .output_float_ctl, .test_select, .core_out,
		.core_oe, .pin_out, .pin_oe, .mgmt_valid, .mgmt_addr, .mgmt_accept,
		.isolated, .test_mode, .strap_ready);
	initial forever #4 hclk = ~hclk;
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic t_reset(input logic [4:0] v);
		@(posedge hclk);
		strap_val <= v;
		mgmt_valid <= 1;
		mgmt_addr <= v;
		rst_req <= 1;
		@(posedge hclk);
		rst_req <= 0;
		#1;
		`CHK({isolated, strap_ready, mgmt_accept}, 3'h4)
		repeat (20) if (strap_ready !== 1'b1) @(posedge hclk);
		`CHK(strap_ready, 1'b1)
		e = 32'h0;
		for (int i = 0; i < 5; i++) e[8 - i] = v[i];
		bus(PSLPC_OFS_STRAP, 0, 32'h0);
		`CHK(r, e)
	endtask
	task automatic t_latch();
		t_reset(5'h0B);
		strap_val <= 5'h14;
		bus(PSLPC_OFS_STRAP, 0, 32'h0);
		`CHK(r, e)
		`CHK({isolated, mgmt_accept}, 2'h1)
		bus(PSLPC_OFS_MGMT, 0, 32'h0);
		`CHK(r, 32'h0000_0001)
		`CHK(hresp, 1'b0)
		mgmt_addr <= 5'h0A;
		@(posedge hclk);
		#1;
		`CHK(mgmt_accept, 1'b0)
	endtask
	task automatic t_iso();
		mgmt_addr <= 5'h0B;
		bus(PSLPC_OFS_CTRL, 1, 32'h0000_0400);
		#1;
		`CHK({isolated, mgmt_accept}, 2'h2)
		bus(8'h20, 0, 32'h0);
		`CHK(r, 32'h0000_0000)
		t_reset(PSLPC_ISO_ADDR);
		`CHK({isolated, mgmt_accept}, 2'h2)
	endtask
	task automatic t_pins();
		for (int i = 0; i < 2; i++) begin
			@(posedge hclk);
			output_float_ctl <= i[0];
			test_select <= i[0];
			@(posedge hclk);
			#1;
			`CHK(pin_oe, i ? 8'h00 : core_oe)
			`CHK(pin_out, i ? 8'h00 : core_out)
			`CHK(test_mode, i[0])
			bus(PSLPC_OFS_STATUS, 0, 32'h0);
			`CHK(r, {29'h0, 1'b1, i[0], i[0]})
		end
	endtask
	task automatic close_out();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Whole run needs well under a thousand cycles
	initial begin
		#40000;
		n_errors++;
		close_out();
	end
	initial begin
		t_latch();
		t_iso();
		t_pins();
		close_out();
	end
endmodule
